// ===== design/oms_pkg.sv
package oms_pkg;
    // register offset and bit layout
    localparam logic [15:0] OMS_MODE_OFFSET = 16'h000b;
    localparam int OMS_MODE_MSB  = 7;
    localparam int OMS_MODE_LSB  = 5;
    localparam int OMS_INTERNAL_VISIBILITY_EN_BIT  = 3;
    localparam int OMS_EMK_BIT   = 1;
    localparam int OMS_EME_BIT   = 0;
    // write takes effect one cycle after the write cycle
    localparam int OMS_APPLY_DELAY = 1;

    typedef enum logic [2:0] {
        OMS_SPECIAL_SC  = 3'h0,
        OMS_EMUL_NARROW = 3'h1,
        OMS_SPECIAL_TST = 3'h2,
        OMS_EMUL_WIDE   = 3'h3,
        OMS_NORMAL_SC   = 3'h4,
        OMS_NORMAL_NAR  = 3'h5,
        OMS_PERIPHERAL  = 3'h6,
        OMS_NORMAL_WIDE = 3'h7
    } oms_mode_e;
endpackage

// ===== design/oms_once_bit.sv
`timescale 1ns/100ps
// one writable bit with per-mode permission: never, once, anytime
module oms_once_bit
    import oms_pkg::*;
(
    input  wire logic mclk,        // system clock
    input  wire logic rst_n,       // sync reset, active low
    input  wire logic rst_val,     // value loaded at reset
    input  wire logic wr,          // write accepted this cycle
    input  wire logic wdata,       // bit value written
    input  wire logic allow_any,   // special modes
    input  wire logic allow_once,  // normal modes
    output logic      q            // registered bit
);
    logic q_reg, q_next;
    logic used_reg, used_next;

    // permission check, once-flag consumed by any accepted write
    always_comb begin
        q_next    = q_reg;
        used_next = used_reg;
        if (wr && (allow_any || (allow_once && !used_reg))) begin
            q_next    = wdata;
            used_next = 1'b1;
        end
    end

    // reset value follows the synced straps, so it is known before release
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q_reg    <= rst_val;
            used_reg <= 1'b0;
        end else begin
            q_reg    <= q_next;
            used_reg <= used_next;
        end
    end

    assign q = q_reg;
endmodule // oms_once_bit

// ===== design/oms_strap_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for external level inputs
module oms_strap_sync #(
    parameter int W = 3
) (
    input  wire logic         mclk,  // system clock
    input  wire logic [W-1:0] d,     // asynchronous level
    output logic [W-1:0]      q      // synchronised level
);
    logic [W-1:0] s1_reg, s2_reg;

    // first stage feeds only the second
    always_ff @(posedge mclk) begin
        s1_reg <= d;
        s2_reg <= s1_reg;
    end

    assign q = s2_reg;
endmodule // oms_strap_sync

// ===== design/oms_mode_reg.sv
`timescale 1ns/100ps
// What this block does
// - mode field at bits 7:5, codes 0..7 name the eight modes
// - reset loads mode from pins; visibility and emulate bits per mode
// - mode field writes ignored while lowest mode bit is one
// - special modes write mode freely, never to or from peripheral
// - normal single chip: top bit fixed, lower bits once, 110 refused
// - special to normal single chip leaves one write, else none
// - secure state blocks all mode field writes
// - accepted writes apply one cycle after the write cycle
// - visibility bit: once normal, never emulation, anytime special
// - port k emulate bit permissions; set in expanded unmaps port k
// - port k mapped in single chip, unmapped in peripheral
// - port e emulate bit writable only special; unmaps in expanded/peripheral
// - port e mapped in single chip whatever the bit
// - register absent in expanded and peripheral, access goes external
// - peripheral mode: inaccessible, reset values still configure chip
// - reads allowed any time the register is in the map
module oms_mode_reg
    import oms_pkg::*;
(
    input  wire logic        mclk,          // system clock
    input  wire logic        rst_n,         // sync reset, active low
    input  wire logic [2:0]  mode_pins,     // mode select pins
    input  wire logic        secure_in,     // secure state level
    input  wire logic [15:0] addr,          // register address
    input  wire logic [7:0]  wdata,         // write data
    input  wire logic        wr_stb,        // write strobe
    input  wire logic        rd_stb,        // read strobe
    output logic [7:0]       rdata,         // read data, cycle after strobe
    output logic [2:0]       mode_sel_field,// current mode
    output logic             internal_visibility_en, // visible internal cycles
    output logic             emulate_port_k,         // port k bit value
    output logic             emulate_port_e,         // port e bit value
    output logic             port_k_mapped, // port k data/direction in map
    output logic             port_e_mapped, // port e data/direction in map
    output logic             ext_forward    // access echoed on external bus
);
    logic [2:0] pins_s;
    logic       secure_s;
    logic [2:0] mode_reg, mode_next;
    logic       mode_once_reg, mode_once_next;
    logic       internal_visibility_en_reg, emk_reg, eme_reg;
    logic       internal_visibility_en_rst, emu_rst;
    logic       init_reg;
    logic       pend_reg, pend_next;
    logic [7:0] pdata_reg, pdata_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       pkm_reg, pem_reg, fwd_reg;
    logic       pkm_next, pem_next, fwd_next;
    logic       in_map, hit, special, emul, normal, single_chip, expanded;
    logic [2:0] wmode;

    oms_strap_sync #(.W(3)) u_pins_sync (
        .mclk (mclk),
        .d    (mode_pins),
        .q    (pins_s)
    );

    oms_strap_sync #(.W(1)) u_sec_sync (
        .mclk (mclk),
        .d    (secure_in),
        .q    (secure_s)
    );

    // visibility bit: once in normal, never in emulation, anytime in special
    oms_once_bit u_internal_visibility_en_bit (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .rst_val    (internal_visibility_en_rst),
        .wr         (pend_reg),
        .wdata      (pdata_reg[OMS_INTERNAL_VISIBILITY_EN_BIT]),
        .allow_any  (special),
        .allow_once (normal),
        .q          (internal_visibility_en_reg)
    );

    // port k emulate bit, same permissions as visibility
    oms_once_bit u_emk_bit (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .rst_val    (emu_rst),
        .wr         (pend_reg),
        .wdata      (pdata_reg[OMS_EMK_BIT]),
        .allow_any  (special),
        .allow_once (normal),
        .q          (emk_reg)
    );

    // port e emulate bit: special modes only, no once permission
    oms_once_bit u_eme_bit (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .rst_val    (emu_rst),
        .wr         (pend_reg),
        .wdata      (pdata_reg[OMS_EME_BIT]),
        .allow_any  (special),
        .allow_once (1'b0),
        .q          (eme_reg)
    );

    // mode class decode
    always_comb begin
        special     = (mode_reg == OMS_SPECIAL_SC) || (mode_reg == OMS_SPECIAL_TST)
                   || (mode_reg == OMS_PERIPHERAL);
        emul        = (mode_reg == OMS_EMUL_NARROW) || (mode_reg == OMS_EMUL_WIDE);
        normal      = mode_reg[2] && (mode_reg != OMS_PERIPHERAL);
        single_chip = !mode_reg[0] && (mode_reg != OMS_PERIPHERAL);
        expanded    = mode_reg[0];
        in_map      = single_chip;
        hit         = (addr == OMS_MODE_OFFSET);
        internal_visibility_en_rst    = !pins_s[2] && (pins_s != 3'h0);
        emu_rst     = !pins_s[2] && pins_s[0];
    end

    // capture write, apply it next cycle; delay hides the change from the write cycle
    always_comb begin
        pend_next  = wr_stb && hit && in_map;
        pdata_next = wdata;
    end

    // apply pending write with per-bit permissions
    always_comb begin
        mode_next      = mode_reg;
        mode_once_next = mode_once_reg;
        wmode          = pdata_reg[OMS_MODE_MSB:OMS_MODE_LSB];
        if (pend_reg) begin
            // mode field
            if (!secure_s && !mode_reg[0]) begin
                if (!mode_reg[2]) begin
                    if (wmode != OMS_PERIPHERAL) begin
                        mode_next      = wmode;
                        mode_once_next = (wmode == OMS_NORMAL_SC);
                    end
                end else if (mode_reg == OMS_NORMAL_SC && mode_once_reg) begin
                    if (wmode[1:0] != 2'h2) begin
                        mode_next      = {1'b1, wmode[1:0]};
                        mode_once_next = 1'b0;
                    end
                end
            end
        end
    end

    // read data in the cycle after the strobe; bits 4 and 2 read zero
    always_comb begin
        rdata_next = 8'h00;
        if (rd_stb && hit && in_map) begin
            rdata_next = {mode_reg, 1'b0, internal_visibility_en_reg, 1'b0, emk_reg, eme_reg};
        end
    end

    // registers; reset values applied the cycle after release from synced pins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            init_reg      <= 1'b1;
            mode_reg      <= 3'h0;
            mode_once_reg <= 1'b1;
            pend_reg      <= 1'b0;
            pdata_reg     <= 8'h00;
            rdata_reg     <= 8'h00;
        end else if (init_reg) begin
            // strap capture after release, reset value per selected mode
            init_reg      <= 1'b0;
            mode_reg      <= pins_s;
            mode_once_reg <= 1'b1;
            pend_reg      <= 1'b0;
            pdata_reg     <= 8'h00;
            rdata_reg     <= 8'h00;
        end else begin
            mode_reg      <= mode_next;
            mode_once_reg <= mode_once_next;
            pend_reg      <= pend_next;
            pdata_reg     <= pdata_next;
            rdata_reg     <= rdata_next;
        end
    end

    // map decode; lags the mode by one cycle in exchange for flopped outputs
    always_comb begin
        pkm_next = single_chip || (expanded && !emk_reg);
        pem_next = single_chip || !eme_reg;
        fwd_next = hit && (wr_stb || rd_stb) && !in_map;
    end

    // map decode registered so every output comes from a flip-flop
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pkm_reg <= 1'b1;
            pem_reg <= 1'b1;
            fwd_reg <= 1'b0;
        end else begin
            pkm_reg <= pkm_next;
            pem_reg <= pem_next;
            fwd_reg <= fwd_next;
        end
    end

    assign rdata                  = rdata_reg;
    assign mode_sel_field         = mode_reg;
    assign internal_visibility_en = internal_visibility_en_reg;
    assign emulate_port_k         = emk_reg;
    assign emulate_port_e         = eme_reg;
    assign port_k_mapped          = pkm_reg;
    assign port_e_mapped          = pem_reg;
    assign ext_forward            = fwd_reg;
endmodule // oms_mode_reg

// ===== tb/oms_mode_reg_chk.sv
`timescale 1ns/100ps
// port-level checks for the mode register
module oms_mode_reg_chk
    import oms_pkg::*;
(
    input wire logic        mclk,                   // clock
    input wire logic        rst_n,                  // reset
    input wire logic [2:0]  mode_pins,              // straps
    input wire logic        secure_in,              // secure
    input wire logic [15:0] addr,                   // address
    input wire logic [7:0]  wdata,                  // write data
    input wire logic        wr_stb,                 // write
    input wire logic        rd_stb,                 // read
    input wire logic [7:0]  rdata,                  // read data
    input wire logic [2:0]  mode_sel_field,         // mode
    input wire logic        internal_visibility_en, // internal_visibility_en
    input wire logic        emulate_port_k,         // emk
    input wire logic        emulate_port_e,         // eme
    input wire logic        port_k_mapped,          // k map
    input wire logic        port_e_mapped,          // e map
    input wire logic        ext_forward             // echo
);
    logic sc, sp, per, acc;

    // mapped outputs lag mode by a cycle, so map checks want two samples
    assign sc  = !mode_sel_field[0] && mode_sel_field != 3'h6;
    assign sp  = !mode_sel_field[2] && !mode_sel_field[0];
    assign per = mode_sel_field == 3'h6;
    assign acc = (wr_stb || rd_stb) && addr == OMS_MODE_OFFSET;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_zero_bits: assert property (rd_stb && addr == OMS_MODE_OFFSET
        |=> !rdata[4] && !rdata[2])
        else $error("reserved bits read nonzero");
    a_absent_echo: assert property (acc && !sc |=> ext_forward && rdata == 8'h00)
        else $error("absent access not echoed");
    a_present_read: assert property (rd_stb && addr == OMS_MODE_OFFSET && sc
        |=> rdata[7:5] == $past(mode_sel_field))
        else $error("read mode mismatch");
    a_lo_locked: assert property (mode_sel_field[0] |=> $stable(mode_sel_field))
        else $error("mode changed with low bit set");
    a_no_periph: assert property ($past(rst_n) |=> $stable(per))
        else $error("peripheral mode entered or left");
    a_secure_lock: assert property (secure_in [*6] ##0 $past(rst_n)
        |=> $stable(mode_sel_field))
        else $error("mode changed while secure");
    a_map_single: assert property (sc && $past(sc) |-> port_k_mapped && port_e_mapped)
        else $error("single chip ports unmapped");
    a_periph_unmap: assert property (per && $past(per) |-> !port_k_mapped)
        else $error("peripheral port k mapped");
    a_internal_visibility_en_apply: assert property (wr_stb && addr == OMS_MODE_OFFSET && sp
        |-> ##2 internal_visibility_en == $past(wdata[3], 2))
        else $error("visibility write not applied");

    c_echo: cover property (acc && !sc);
    c_spec_wr: cover property (wr_stb && sp);
    c_secure_wr: cover property (secure_in [*6] ##1 wr_stb);
endmodule // oms_mode_reg_chk

bind oms_mode_reg oms_mode_reg_chk u_chk (
    .mclk                   (mclk),
    .rst_n                  (rst_n),
    .mode_pins              (mode_pins),
    .secure_in              (secure_in),
    .addr                   (addr),
    .wdata                  (wdata),
    .wr_stb                 (wr_stb),
    .rd_stb                 (rd_stb),
    .rdata                  (rdata),
    .mode_sel_field         (mode_sel_field),
    .internal_visibility_en (internal_visibility_en),
    .emulate_port_k         (emulate_port_k),
    .emulate_port_e         (emulate_port_e),
    .port_k_mapped          (port_k_mapped),
    .port_e_mapped          (port_e_mapped),
    .ext_forward            (ext_forward)
);

// ===== tb/oms_mode_reg_tb.sv
`timescale 1ns/100ps
// directed bench for the mode register
module oms_mode_reg_tb
    import oms_pkg::*;
;
    logic        mclk = 0, rst_n = 0, secure_in = 0, wr_stb = 0, rd_stb = 0;
    logic [2:0]  mode_pins = 3'h0;
    logic [15:0] addr = 16'h000b;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic [2:0]  mode_sel_field;
    logic        internal_visibility_en, emulate_port_k, emulate_port_e;
    logic        port_k_mapped, port_e_mapped, ext_forward;
    int          miscompares = 0, cmp_count = 0;

    oms_mode_reg dut (
        .mclk                   (mclk),
        .rst_n                  (rst_n),
        .mode_pins              (mode_pins),
        .secure_in              (secure_in),
        .addr                   (addr),
        .wdata                  (wdata),
        .wr_stb                 (wr_stb),
        .rd_stb                 (rd_stb),
        .rdata                  (rdata),
        .mode_sel_field         (mode_sel_field),
        .internal_visibility_en (internal_visibility_en),
        .emulate_port_k         (emulate_port_k),
        .emulate_port_e         (emulate_port_e),
        .port_k_mapped          (port_k_mapped),
        .port_e_mapped          (port_e_mapped),
        .ext_forward            (ext_forward)
    );

    always #50 mclk = ~mclk;

    task chk(string what, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // straps settle during the long reset; task returns three edges after release, first access driven after the fourth
    task rst(input logic [2:0] p);
        @(posedge mclk);
        rst_n <= 1'b0;
        mode_pins <= p;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // waits out the one-cycle apply delay before returning
    task wr(input logic [7:0] d);
        @(posedge mclk);
        addr <= OMS_MODE_OFFSET;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task rd(output logic [7:0] d, output logic f);
        @(posedge mclk);
        addr <= OMS_MODE_OFFSET;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
        f = ext_forward;
    endtask

    task t_reset_table;
        logic [7:0] v, d;
        logic       f, ivs, em, in_map;
        for (int p = 0; p < 8; p++) begin
            rst(p[2:0]);
            ivs = p >= 1 && p <= 3;
            em = p == 1 || p == 3;
            in_map = p == 0 || p == 2 || p == 4;
            v = {p[2:0], 1'b0, ivs, 1'b0, em, em};
            chk("mode", mode_sel_field, p[2:0]);
            chk("bits", {internal_visibility_en, emulate_port_k, emulate_port_e}, {ivs, em, em});
            chk("k map", port_k_mapped, in_map || (p != 6 && !em));
            chk("e map", port_e_mapped, in_map || !em);
            if (!in_map)
                wr(8'h00);
            rd(d, f);
            chk("read", d, in_map ? v : 8'h00);
            chk("echo", f, !in_map);
            chk("mode kept", mode_sel_field, p[2:0]);
        end
        $display("test reset_table done");
    endtask

    task t_special_walk;
        logic [7:0] d;
        logic       f;
        rst(3'h0);
        wr(8'h1f);
        rd(d, f);
        chk("bits", d, 8'h0b);
        wr(8'hcb);
        chk("mode", mode_sel_field, 8'h00);
        wr(8'h40);
        chk("mode", mode_sel_field, 8'h02);
        @(posedge mclk);
        secure_in <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(8'h00);
        chk("mode", mode_sel_field, 8'h02);
        @(posedge mclk);
        secure_in <= 1'b0;
        repeat (4) @(posedge mclk);
        wr(8'h82);
        chk("mode", mode_sel_field, 8'h04);
        wr(8'hc2);
        chk("mode", mode_sel_field, 8'h04);
        wr(8'he2);
        chk("mode", mode_sel_field, 8'h07);
        chk("k map", port_k_mapped, 8'h00);
        chk("e map", port_e_mapped, 8'h01);
        wr(8'h02);
        chk("mode", mode_sel_field, 8'h07);
        $display("test special_walk done");
    endtask

    // normal single chip: mode low bits, visibility and port k take one write
    task t_normal_once;
        logic [7:0] d;
        logic       f;
        rst(3'h4);
        wr(8'h8b);
        rd(d, f);
        chk("bits", d, 8'h8a);
        wr(8'he0);
        rd(d, f);
        chk("bits", d, 8'h8a);
        chk("mode", mode_sel_field, 8'h04);
        chk("k map", port_k_mapped, 8'h01);
        $display("test normal_once done");
    endtask

    initial begin
        #2ms;
        miscompares++;
        tally_and_finish;
    end

    initial begin
        t_reset_table;
        t_special_walk;
        t_normal_once;
        tally_and_finish;
    end
endmodule // oms_mode_reg_tb
